// ### mwdt_defs.svh
// Register offsets, field positions, reset values and timing constants of the watchdog.
`ifndef MWDT_DEFS_SVH
`define MWDT_DEFS_SVH
`define MWDT_ADDR_CTRL      16'h7F37
`define MWDT_ADDR_COUNT     16'h7F38
`define MWDT_BIT_UNLOCK     0
`define MWDT_BIT_ENABLE     1
`define MWDT_CTRL_RESET     8'h00
`define MWDT_COUNT_RESET    8'hFF
`define MWDT_COUNT_DISABLE  8'h00
`define MWDT_COUNT_LAST     8'h01
`define MWDT_PRESCALE_DIV   512
`define MWDT_PRESCALE_LAST  9'h1FF
`define MWDT_PRESCALE_ZERO  9'h000
`endif

// ### mwdt_fw_model.sv
// Firmware model that drives the watchdog registers and the slow clock.
`timescale 1ns/10ps
`default_nettype none
module mwdt_fw_model (
  input  wire logic               i_clk,
  input  wire logic [7:0]         i_rdata,
  output mwdt_pkg::mwdt_bus_req_t o_bus,
  output logic                    o_clk32k
);
  // The slow clock runs free but faster than 32 kHz, eight cycles a period, to keep runs short.
  initial begin
    o_bus = '0;
    o_clk32k = 1'b0;
    forever #80 o_clk32k = ~o_clk32k;
  end

  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge i_clk);
    o_bus = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge i_clk);
    o_bus = '0;
    q = i_rdata;
  endtask

  task automatic reload(input logic [7:0] v);
    logic [7:0] q;
    access(1'b1, 16'h7F37, 8'h03, q);
    access(1'b1, 16'h7F38, v, q);
  endtask
endmodule
`default_nettype wire

// ### mwdt_pkg.sv
// Types shared by the watchdog modules.
package mwdt_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mwdt_bus_req_t;
  typedef struct packed {
    logic enable;
    logic unlock;
  } mwdt_ctrl_t;
endpackage

// ### mwdt_prescaler.sv
// Prescaler that divides the slow clock ticks down to one watchdog tick.
`timescale 1ns/10ps
`default_nettype none
`include "mwdt_defs.svh"
module mwdt_prescaler #(
  parameter int unsigned DIV = `MWDT_PRESCALE_DIV
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_ce,
  input  wire logic i_clear,
  input  wire logic i_run,
  input  wire logic i_slow_tick,
  output logic      o_tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    o_tick   = 1'b0;
    if (i_clear || !i_run) begin
      cnt_next = '0;
    end else if (i_slow_tick) begin
      if (cnt_reg == LAST) begin
        cnt_next = '0;
        o_tick   = 1'b1;
      end else begin
        cnt_next = W'(cnt_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// ### mwdt_sync.sv
// Three-stage synchroniser for the slow tick clock arriving from outside.
`timescale 1ns/10ps
`default_nettype none
module mwdt_sync (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_rise
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       level_reg;
  logic       level_next;

  always_comb begin
    sync_next  = {sync_reg[1:0], i_async};
    level_next = level_reg;
    // A change counts only once stages two and three agree.
    if (sync_reg[1] == sync_reg[2]) begin
      level_next = sync_reg[2];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end else if (i_ce) begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign o_rise = i_ce & level_next & ~level_reg;
endmodule
`default_nettype wire

// ### mwdt_top.sv
// Watchdog of the embedded controller with its two memory-mapped registers.
`timescale 1ns/10ps
`default_nettype none
`include "mwdt_defs.svh"
// Contract
// - Eight-bit down counter driven through a nine-bit prescaler from free 32 kHz.
// - Counter decrements once every 512 slow clock cycles, 16 ms.
// - Enabled counter underflow raises a standby-domain power-on reset.
// - Counting continues during controller idle; underflow in idle still resets.
// - Inactive after reset; starts only when firmware sets enable bit D1.
// - Counter writes accepted only while unlock bit D0 is set.
// - Any counter write clears the unlock bit automatically.
// - Reload value sets interval in 16 ms steps, 01h to FFh.
// - Unlocked write of 00h clears enable and unlock bits.
// - Prescaler restarts whenever the counter register is loaded.
// - Reset values: counter FFh, control/status 00h.
module mwdt_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_ce,
  input  wire logic                  i_clk32k,
  input  wire mwdt_pkg::mwdt_bus_req_t i_bus,
  output logic [7:0]                 o_rdata,
  output logic                       o_por,
  output logic                       o_enabled,
  output logic [7:0]                 o_count
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  mwdt_pkg::mwdt_ctrl_t ctrl_reg;
  mwdt_pkg::mwdt_ctrl_t ctrl_next;
  logic [7:0]           count_reg;
  logic [7:0]           count_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic                 por_reg;
  logic                 por_next;
  logic                 slow_tick;
  logic                 wd_tick;
  logic                 count_wr;
  logic                 ctrl_wr;
  logic                 load;

  // ------------------------------------------------------------
  // Slow clock and prescaler
  // ------------------------------------------------------------
  mwdt_sync u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_async (i_clk32k),
    .o_rise  (slow_tick)
  );

  mwdt_prescaler #(
    .DIV (`MWDT_PRESCALE_DIV)
  ) u_pre (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_ce        (i_ce),
    .i_clear     (load | por_reg),
    .i_run       (ctrl_reg.enable),
    .i_slow_tick (slow_tick),
    .o_tick      (wd_tick)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  always_comb begin
    ctrl_wr  = 1'b0;
    count_wr = 1'b0;
    if (i_bus.wr && i_bus.addr == `MWDT_ADDR_CTRL) begin
      ctrl_wr = 1'b1;
    end else if (i_bus.wr && i_bus.addr == `MWDT_ADDR_COUNT) begin
      count_wr = 1'b1;
    end
  end

  assign load = count_wr & ctrl_reg.unlock;

  // ------------------------------------------------------------
  // Control, counter and reset generation
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next  = ctrl_reg;
    count_next = count_reg;
    por_next   = 1'b0;
    rdata_next = rdata_reg;
    if (por_reg) begin
      // The generated reset restores power-on values.
      ctrl_next.enable = 1'b0;
      ctrl_next.unlock = 1'b0;
      count_next       = `MWDT_COUNT_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_next.enable = i_bus.wdata[`MWDT_BIT_ENABLE];
        ctrl_next.unlock = i_bus.wdata[`MWDT_BIT_UNLOCK];
      end
      if (count_wr) begin
        ctrl_next.unlock = 1'b0;
      end
      if (load) begin
        count_next = i_bus.wdata;
        if (i_bus.wdata == `MWDT_COUNT_DISABLE) begin
          ctrl_next.enable = 1'b0;
        end
      end else if (ctrl_reg.enable && wd_tick) begin
        // Idle does not stop this path: only enable and the slow clock matter.
        if (count_reg == `MWDT_COUNT_LAST) begin
          por_next = 1'b1;
        end
        count_next = 8'(count_reg - 8'h01);
      end
    end
    if (i_bus.rd && i_bus.addr == `MWDT_ADDR_CTRL) begin
      rdata_next = {6'h00, ctrl_reg.enable, ctrl_reg.unlock};
    end else if (i_bus.rd && i_bus.addr == `MWDT_ADDR_COUNT) begin
      rdata_next = count_reg;
    end else if (i_bus.rd) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg  <= '0;
      count_reg <= `MWDT_COUNT_RESET;
      por_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      ctrl_reg  <= ctrl_next;
      count_reg <= count_next;
      por_reg   <= por_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata   = rdata_reg;
  assign o_por     = por_reg;
  assign o_enabled = ctrl_reg.enable;
  assign o_count   = count_reg;

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  // Counts slow clock rises since the prescaler last restarted, as an
  // independent measure of the watchdog tick period.
  logic [9:0] slow_cnt_reg;
  logic [9:0] slow_cnt_next;

  always_comb begin
    slow_cnt_next = slow_cnt_reg;
    if (load || por_reg || !ctrl_reg.enable || wd_tick) begin
      slow_cnt_next = 10'h000;
    end else if (slow_tick && slow_cnt_reg != 10'h3FF) begin
      slow_cnt_next = 10'(slow_cnt_reg + 10'h001);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      slow_cnt_reg <= 10'h000;
    end else if (i_ce) begin
      slow_cnt_reg <= slow_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // ------------------------------------------------------------
  // Register write checks
  // ------------------------------------------------------------
  // Writes land at the edge that takes them and show one cycle later.
  a_locked_write_ignored: assert property (
    (i_ce && !por_reg && count_wr && !ctrl_reg.unlock && !(ctrl_reg.enable && wd_tick))
      |=> $stable(count_reg))
    else $error("Locked counter write changed counter.");
  a_unlock_self_clears: assert property (
    (i_ce && count_wr) |=> !ctrl_reg.unlock)
    else $error("Unlock bit survived counter write.");
  a_unlock_source: assert property (
    $rose(ctrl_reg.unlock) |-> $past(ctrl_wr))
    else $error("Unlock bit set without a control write.");
  a_ctrl_write_sets: assert property (
    (i_ce && !por_reg && ctrl_wr &&
     i_bus.wdata[`MWDT_BIT_ENABLE] && i_bus.wdata[`MWDT_BIT_UNLOCK])
      |=> ctrl_reg.enable && ctrl_reg.unlock)
    else $error("Control write did not set both bits.");
  a_ctrl_write_clears: assert property (
    (i_ce && !por_reg && ctrl_wr &&
     !i_bus.wdata[`MWDT_BIT_ENABLE] && !i_bus.wdata[`MWDT_BIT_UNLOCK])
      |=> !ctrl_reg.enable && !ctrl_reg.unlock)
    else $error("Control write did not clear both bits.");
  a_unmapped_wr_ignored: assert property (
    (i_ce && !por_reg && i_bus.wr && !ctrl_wr && !count_wr && !(ctrl_reg.enable && wd_tick))
      |=> $stable(count_reg) && $stable(ctrl_reg))
    else $error("Unmapped write changed a register.");

  // ------------------------------------------------------------
  // Counter load checks
  // ------------------------------------------------------------
  // A load wins over a tick in the same cycle.
  a_load_takes_value: assert property (
    (i_ce && !por_reg && load) |=> count_reg == $past(i_bus.wdata))
    else $error("Counter load value lost.");
  a_zero_disables: assert property (
    (i_ce && !por_reg && load && i_bus.wdata == `MWDT_COUNT_DISABLE)
      |=> !ctrl_reg.enable && !ctrl_reg.unlock)
    else $error("Write of zero did not disable.");
  a_load_restarts_pre: assert property (
    (i_ce && !por_reg && load) |=> u_pre.cnt_reg == `MWDT_PRESCALE_ZERO)
    else $error("Prescaler not restarted by a load.");
  a_count_source: assert property (
    $changed(count_reg) |-> $past(load) || $past(por_reg) ||
      ($past(wd_tick) && $past(ctrl_reg.enable)))
    else $error("Counter changed without load, tick or reset.");

  // ------------------------------------------------------------
  // Counting checks
  // ------------------------------------------------------------
  // The helper counter measures the prescaler from outside.
  a_tick_period: assert property (
    wd_tick |-> slow_cnt_reg == 10'(`MWDT_PRESCALE_DIV - 1))
    else $error("Watchdog tick period is not one prescaler cycle.");
  a_tick_decrements: assert property (
    (i_ce && !por_reg && !load && ctrl_reg.enable && wd_tick)
      |=> count_reg == 8'($past(count_reg) - 8'h01))
    else $error("Tick did not decrement counter.");
  a_tick_needs_enable: assert property (
    wd_tick |-> ctrl_reg.enable)
    else $error("Watchdog tick while disabled.");
  a_disabled_holds: assert property (
    (i_ce && !ctrl_reg.enable && !load && !por_reg) |=> $stable(count_reg))
    else $error("Counter moved while disabled.");
  a_pre_held_disabled: assert property (
    (i_ce && !ctrl_reg.enable) |=> u_pre.cnt_reg == `MWDT_PRESCALE_ZERO)
    else $error("Prescaler ran while disabled.");
  a_enable_source: assert property (
    $rose(ctrl_reg.enable) |-> $past(ctrl_wr))
    else $error("Enable set without a control write.");
  a_freeze: assert property (
    !i_ce |=> $stable(count_reg) && $stable(ctrl_reg) && $stable(por_reg))
    else $error("State moved while the clock enable was low.");

  // ------------------------------------------------------------
  // Generated reset checks
  // ------------------------------------------------------------
  // The generated reset is a single-cycle pulse.
  a_underflow_por: assert property (
    (i_ce && !por_reg && !load && ctrl_reg.enable && wd_tick &&
     count_reg == `MWDT_COUNT_LAST) |=> por_reg)
    else $error("Underflow did not raise reset.");
  a_por_needs_enable: assert property (
    (i_ce && !ctrl_reg.enable) |=> !por_reg)
    else $error("Reset raised while disabled.");
  a_por_single: assert property (
    (i_ce && por_reg) |=> !por_reg)
    else $error("Reset pulse longer than one cycle.");
  a_por_cause: assert property (
    $rose(por_reg) |-> $past(ctrl_reg.enable) && $past(count_reg) == `MWDT_COUNT_LAST)
    else $error("Reset raised without underflow.");
  a_por_restores: assert property (
    (i_ce && por_reg)
      |=> count_reg == `MWDT_COUNT_RESET && !ctrl_reg.enable && !ctrl_reg.unlock)
    else $error("Reset did not restore power-on values.");

  // ------------------------------------------------------------
  // Read data checks
  // ------------------------------------------------------------
  // Read data shows the register value from the cycle the read was taken.
  a_rd_ctrl: assert property (
    (i_ce && i_bus.rd && i_bus.addr == `MWDT_ADDR_CTRL)
      |=> o_rdata == {6'h00, $past(ctrl_reg.enable), $past(ctrl_reg.unlock)})
    else $error("Control read returned wrong data.");
  a_rd_count: assert property (
    (i_ce && i_bus.rd && i_bus.addr == `MWDT_ADDR_COUNT) |=> o_rdata == $past(count_reg))
    else $error("Counter read returned wrong data.");
  a_rd_unmapped: assert property (
    (i_ce && i_bus.rd && i_bus.addr != `MWDT_ADDR_CTRL && i_bus.addr != `MWDT_ADDR_COUNT)
      |=> o_rdata == 8'h00)
    else $error("Unmapped read returned nonzero data.");

  c_reload: cover property (i_ce && load && i_bus.wdata != 8'h00);
  c_disable: cover property (i_ce && load && i_bus.wdata == 8'h00);
  c_underflow: cover property ($rose(por_reg));
  c_locked_write: cover property (i_ce && count_wr && !ctrl_reg.unlock);
  c_ce_freeze: cover property (!i_ce && ctrl_reg.enable);
endmodule
`default_nettype wire

// ### mwdt_top_test.sv
// Self-checking testbench of the watchdog block.
`timescale 1ns/10ps
`default_nettype none
module mwdt_top_test;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  cnt;
    logic [7:0]  ctl;
  } mwdt_row_t;
  logic                    clk;
  logic                    i_reset;
  logic                    ce;
  mwdt_pkg::mwdt_bus_req_t bus;
  logic                    clk32k;
  logic [7:0]              o_rdata;
  logic                    o_por;
  logic                    o_enabled;
  logic [7:0]              o_count;
  logic [7:0]              q;
  int                      errors;
  int                      cmp_count;
  int                      n;
  mwdt_row_t               rows [0:6];

  mwdt_top mwdt_top_inst (.i_clk(clk), .i_reset(i_reset), .i_ce(ce), .i_clk32k(clk32k),
    .i_bus(bus), .o_rdata(o_rdata), .o_por(o_por), .o_enabled(o_enabled), .o_count(o_count));
  mwdt_fw_model mwdt_fw_model_inst (.i_clk(clk), .i_rdata(o_rdata), .o_bus(bus),
    .o_clk32k(clk32k));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_change(input logic [7:0] v);
    n = 0;
    while (o_count === v && o_por !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    i_reset = 1'b1;
    rows = '{{16'h7F38, 8'h55, 8'hFF, 8'h00}, {16'h7F37, 8'h03, 8'hFF, 8'h03},
             {16'h7F38, 8'h40, 8'h40, 8'h02}, {16'h7F38, 8'h20, 8'h40, 8'h02},
             {16'h7F37, 8'hFF, 8'h40, 8'h03}, {16'h7F38, 8'h00, 8'h00, 8'h00},
             {16'h7F00, 8'hAA, 8'h00, 8'h00}};
    ce = 1'b1;
    repeat (4) @(negedge clk);
    check(o_count, 8'hFF, "count at reset");
    check({7'h00, o_enabled}, 8'h00, "enable at reset");
    i_reset = 1'b0;
    mwdt_fw_model_inst.access(1'b0, 16'h7F37, 8'h00, q);
    check(q, 8'h00, "ctrl reset read");
    mwdt_fw_model_inst.access(1'b0, 16'h7F38, 8'h00, q);
    check(q, 8'hFF, "count reset read");
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      mwdt_fw_model_inst.access(1'b1, rows[i].a, rows[i].d, q);
      check(o_count, rows[i].cnt, "row count");
      check({7'h00, o_enabled}, {7'h00, rows[i].ctl[1]}, "row enable");
      mwdt_fw_model_inst.access(1'b0, 16'h7F37, 8'h00, q);
      check(q, rows[i].ctl, "row ctrl");
    end
    $display("table test done");
    mwdt_fw_model_inst.reload(8'h02);
    repeat (3000) @(negedge clk);
    mwdt_fw_model_inst.reload(8'h02);
    wait_change(8'h02);
    check({7'h00, n inside {[4076:4120]}}, 8'h01, "tick time");
    check(o_count, 8'h01, "count after tick");
    wait_change(8'h01);
    check({7'h00, o_por}, 8'h01, "reset pulse");
    check({7'h00, n inside {[4076:4120]}}, 8'h01, "reset time");
    @(negedge clk);
    check({7'h00, o_por}, 8'h00, "pulse ends");
    check(o_count, 8'hFF, "count restored");
    check({7'h00, o_enabled}, 8'h00, "enable restored");
    repeat (5000) @(negedge clk);
    check(o_count, 8'hFF, "idle when disabled");
    $display("timing test done");
    mwdt_fw_model_inst.reload(8'h02);
    ce = 1'b0;
    repeat (5000) @(negedge clk);
    check(o_count, 8'h02, "frozen by clock enable");
    check({7'h00, o_enabled}, 8'h01, "enable kept while frozen");
    ce = 1'b1;
    $display("clock enable test done");
    i_reset = 1'b1;
    repeat (2) @(negedge clk);
    i_reset = 1'b0;
    check(o_count, 8'hFF, "count after mid reset");
    check({7'h00, o_enabled}, 8'h00, "enable after mid reset");
    mwdt_fw_model_inst.access(1'b0, 16'h7F37, 8'h00, q);
    check(q, 8'h00, "ctrl after mid reset");
    $display("mid reset test done");
    conclude();
  end

  initial begin
    repeat (40000) @(negedge clk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
